// ---- hdl/dld_top.sv ----
// Dead line / live line detector with APB settings and status
//
// What this block does
// - Dead line flag only when all voltages and all currents are low.
// - Live line flag when all three voltages exceed the threshold.
// - Operation switch Off or On, Off after reset.
// - Voltage threshold 10 to 100 percent, step 1, default 60.
// - Current threshold 2 to 100 percent, step 1, default 10.
// - Three per-phase flags: phase voltage above its threshold.
// - Three per-phase flags: phase current above its threshold.
// - Dead and live conditions readable as status besides outputs.
`default_nettype none
`include "dld_map.svh"

module dld_top (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`DLD_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [`DLD_MAG_W-1:0] PHASE1_VOLTAGE_FUNDAMENTAL,
  input wire logic [`DLD_MAG_W-1:0] PHASE2_VOLTAGE_FUNDAMENTAL,
  input wire logic [`DLD_MAG_W-1:0] PHASE3_VOLTAGE_FUNDAMENTAL,
  input wire logic [`DLD_MAG_W-1:0] PHASE1_CURRENT_FUNDAMENTAL,
  input wire logic [`DLD_MAG_W-1:0] PHASE2_CURRENT_FUNDAMENTAL,
  input wire logic [`DLD_MAG_W-1:0] PHASE3_CURRENT_FUNDAMENTAL,
  input wire logic FUNCTION_BLOCK_IN,
  output logic PHASE1_VOLTAGE_ABOVE,
  output logic PHASE2_VOLTAGE_ABOVE,
  output logic PHASE3_VOLTAGE_ABOVE,
  output logic PHASE1_CURRENT_ABOVE,
  output logic PHASE2_CURRENT_ABOVE,
  output logic PHASE3_CURRENT_ABOVE,
  output logic DEAD_LINE_OUT,
  output logic LIVE_LINE_OUT
);

  // =====================================================================
  // Helpers
  // Address match, used by both the write and the read decode
  function automatic logic dld_hit(
    input logic [`DLD_ADDR_W-1:0] addr,
    input logic [`DLD_ADDR_W-1:0] off
  );
    return addr == off;
  endfunction

  // Keeps a written percentage inside its legal range
  function automatic logic [`DLD_PCT_W-1:0] dld_clamp(
    input logic [31:0] val,
    input logic [`DLD_PCT_W-1:0] lo,
    input logic [`DLD_PCT_W-1:0] hi
  );
    logic [`DLD_PCT_W-1:0] res;
    res = val[`DLD_PCT_W-1:0];
    if (val > {25'h0, hi}) begin
      res = hi;
    end else if (val < {25'h0, lo}) begin
      res = lo;
    end
    return res;
  endfunction

  // =====================================================================
  // Declarations
  logic op_q;
  logic [`DLD_PCT_W-1:0] vthr_q;
  logic [`DLD_PCT_W-1:0] ithr_q;
  logic [`DLD_MAG_W-1:0] vnom_q;
  logic [`DLD_MAG_W-1:0] inom_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata_d;
  logic mapped_d;
  logic acc;
  logic wr_fire;
  logic en;
  dld_pkg::dld_meas_type meas;
  dld_pkg::dld_flags_type flags_q;
  logic [2:0] v_above_c;
  logic [2:0] i_above_c;

  // =====================================================================
  // Measurement inputs
  // Fundamentals come ready from the preparation stage, no filtering here
  assign meas.volt = {PHASE3_VOLTAGE_FUNDAMENTAL,
                      PHASE2_VOLTAGE_FUNDAMENTAL,
                      PHASE1_VOLTAGE_FUNDAMENTAL};
  assign meas.curr = {PHASE3_CURRENT_FUNDAMENTAL,
                      PHASE2_CURRENT_FUNDAMENTAL,
                      PHASE1_CURRENT_FUNDAMENTAL};

  // =====================================================================
  // APB handshake
  // Access phase lasts two cycles; PREADY comes from a flop so the bus
  // output has no combinational path from PADDR.
  assign acc = PSEL & PENABLE;
  assign wr_fire = acc & pready_q & PWRITE;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= acc & ~pready_q;
    end
  end

  // Read data and error are taken in the cycle before PREADY
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (acc & ~pready_q) begin
      prdata_q <= PWRITE ? 32'h00000000 : rdata_d;
      pslverr_q <= ~mapped_d;
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // Read mux; status bits show the registered decision flags
  always_comb begin
    rdata_d = 32'h00000000;
    mapped_d = 1'b1;
    if (dld_hit(PADDR, `DLD_OFF_CTRL)) begin
      rdata_d[`DLD_CTRL_OP] = op_q;
    end else if (dld_hit(PADDR, `DLD_OFF_VTHR)) begin
      rdata_d[`DLD_PCT_W-1:0] = vthr_q;
    end else if (dld_hit(PADDR, `DLD_OFF_ITHR)) begin
      rdata_d[`DLD_PCT_W-1:0] = ithr_q;
    end else if (dld_hit(PADDR, `DLD_OFF_VNOM)) begin
      rdata_d[`DLD_MAG_W-1:0] = vnom_q;
    end else if (dld_hit(PADDR, `DLD_OFF_INOM)) begin
      rdata_d[`DLD_MAG_W-1:0] = inom_q;
    end else if (dld_hit(PADDR, `DLD_OFF_STATUS)) begin
      rdata_d[`DLD_ST_DEAD] = flags_q.dead;
      rdata_d[`DLD_ST_LIVE] = flags_q.live;
      rdata_d[`DLD_ST_VOLT_MSB:`DLD_ST_VOLT_LSB] = flags_q.volt_above;
      rdata_d[`DLD_ST_CURR_MSB:`DLD_ST_CURR_LSB] = flags_q.curr_above;
    end else begin
      mapped_d = 1'b0;
    end
  end

  assign PREADY = pready_q;
  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q;

  // =====================================================================
  // Settings
  // Operation switch
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      op_q <= 1'b0;
    end else if (wr_fire && dld_hit(PADDR, `DLD_OFF_CTRL)) begin
      op_q <= PWDATA[`DLD_CTRL_OP];
    end
  end

  // Voltage threshold; out of range writes saturate rather than fault,
  // so a careless write can never leave an illegal setting behind
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      vthr_q <= `DLD_VTHR_RST;
    end else if (wr_fire && dld_hit(PADDR, `DLD_OFF_VTHR)) begin
      vthr_q <= dld_clamp(PWDATA, `DLD_VTHR_MIN, `DLD_VTHR_MAX);
    end
  end

  // Current threshold
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ithr_q <= `DLD_ITHR_RST;
    end else if (wr_fire && dld_hit(PADDR, `DLD_OFF_ITHR)) begin
      ithr_q <= dld_clamp(PWDATA, `DLD_ITHR_MIN, `DLD_ITHR_MAX);
    end
  end

  // Nominal magnitudes that the percentages refer to
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      vnom_q <= `DLD_VNOM_RST;
      inom_q <= `DLD_INOM_RST;
    end else if (wr_fire) begin
      if (dld_hit(PADDR, `DLD_OFF_VNOM)) begin
        vnom_q <= PWDATA[`DLD_MAG_W-1:0];
      end
      if (dld_hit(PADDR, `DLD_OFF_INOM)) begin
        inom_q <= PWDATA[`DLD_MAG_W-1:0];
      end
    end
  end

  // =====================================================================
  // Comparators, one per phase and quantity
  for (genvar ph = 0; ph < 3; ph++) begin : g_phase
    dld_cmp u_volt (
      .mag(meas.volt[ph]),
      .pct(vthr_q),
      .nom(vnom_q),
      .above(v_above_c[ph])
    );
    dld_cmp u_curr (
      .mag(meas.curr[ph]),
      .pct(ithr_q),
      .nom(inom_q),
      .above(i_above_c[ph])
    );
  end

  // =====================================================================
  // Decision logic
  // Blocking overrides the switch; one cycle of latency is negligible
  // against the fundamental update rate.
  assign en = op_q & ~FUNCTION_BLOCK_IN;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      flags_q <= '0;
    end else if (!en) begin
      flags_q <= '0;
    end else begin
      flags_q.volt_above <= v_above_c;
      flags_q.curr_above <= i_above_c;
      flags_q.dead <= ~|v_above_c & ~|i_above_c;
      flags_q.live <= &v_above_c;
    end
  end

  assign PHASE1_VOLTAGE_ABOVE = flags_q.volt_above[0];
  assign PHASE2_VOLTAGE_ABOVE = flags_q.volt_above[1];
  assign PHASE3_VOLTAGE_ABOVE = flags_q.volt_above[2];
  assign PHASE1_CURRENT_ABOVE = flags_q.curr_above[0];
  assign PHASE2_CURRENT_ABOVE = flags_q.curr_above[1];
  assign PHASE3_CURRENT_ABOVE = flags_q.curr_above[2];
  assign DEAD_LINE_OUT = flags_q.dead;
  assign LIVE_LINE_OUT = flags_q.live;

  // =====================================================================
  // Assertions
  a_dead_all_low: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    en && !(|v_above_c) && !(|i_above_c) |=> DEAD_LINE_OUT
  ) else $error("dead line not raised with all phases low");

  a_dead_needs_low: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    DEAD_LINE_OUT |-> $past(!(|v_above_c) && !(|i_above_c) && en)
  ) else $error("dead line raised while a phase was above");

  a_live_all_high: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    en && (&v_above_c) |=> LIVE_LINE_OUT && !DEAD_LINE_OUT
  ) else $error("live line not raised with all voltages above");

  a_op_write_takes: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    wr_fire && dld_hit(PADDR, `DLD_OFF_CTRL)
      |=> op_q == $past(PWDATA[`DLD_CTRL_OP])
  ) else $error("operation switch did not follow the write");

  a_vthr_in_range: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    vthr_q >= `DLD_VTHR_MIN && vthr_q <= `DLD_VTHR_MAX
  ) else $error("voltage threshold out of range");

  a_ithr_in_range: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    ithr_q >= `DLD_ITHR_MIN && ithr_q <= `DLD_ITHR_MAX
  ) else $error("current threshold out of range");

  a_block_quiets_all: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (!op_q || FUNCTION_BLOCK_IN) |=> !DEAD_LINE_OUT && !LIVE_LINE_OUT
      && !(|flags_q.volt_above) && !(|flags_q.curr_above)
  ) else $error("outputs active while off or blocked");

  a_volt_flags_follow: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    en |=> {PHASE3_VOLTAGE_ABOVE, PHASE2_VOLTAGE_ABOVE,
            PHASE1_VOLTAGE_ABOVE} == $past(v_above_c)
  ) else $error("voltage flags do not follow the comparators");

  a_curr_flags_follow: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    en |=> {PHASE3_CURRENT_ABOVE, PHASE2_CURRENT_ABOVE,
            PHASE1_CURRENT_ABOVE} == $past(i_above_c)
  ) else $error("current flags do not follow the comparators");

  a_status_read_ok: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    PREADY && !PWRITE && dld_hit(PADDR, `DLD_OFF_STATUS)
      |-> PRDATA[`DLD_ST_DEAD] == $past(DEAD_LINE_OUT)
      && PRDATA[`DLD_ST_LIVE] == $past(LIVE_LINE_OUT)
  ) else $error("status read disagrees with line outputs");

  a_pready_timing: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    PSEL && PENABLE && !PREADY |=> PREADY
  ) else $error("ready not given one cycle into the access");

endmodule

`default_nettype wire

// ---- include/dld_map.svh ----
// Register offsets, field positions, reset values and limits of the detector
`ifndef DLD_MAP_SVH
`define DLD_MAP_SVH

// =====================================================================
// Widths
`define DLD_ADDR_W 8
`define DLD_MAG_W 16
`define DLD_PCT_W 7

// =====================================================================
// Register byte offsets on APB
`define DLD_OFF_CTRL 8'h00
`define DLD_OFF_VTHR 8'h04
`define DLD_OFF_ITHR 8'h08
`define DLD_OFF_VNOM 8'h0C
`define DLD_OFF_INOM 8'h10
`define DLD_OFF_STATUS 8'h14

// =====================================================================
// Field positions
`define DLD_CTRL_OP 0
`define DLD_ST_DEAD 0
`define DLD_ST_LIVE 1
`define DLD_ST_VOLT_LSB 2
`define DLD_ST_VOLT_MSB 4
`define DLD_ST_CURR_LSB 5
`define DLD_ST_CURR_MSB 7

// =====================================================================
// Threshold limits and reset values, in percent
`define DLD_VTHR_MIN 7'h0A
`define DLD_VTHR_MAX 7'h64
`define DLD_VTHR_RST 7'h3C
`define DLD_ITHR_MIN 7'h02
`define DLD_ITHR_MAX 7'h64
`define DLD_ITHR_RST 7'h0A
`define DLD_PCT_SCALE 7'h64

// Nominal magnitudes after reset, in the units of the magnitude inputs
`define DLD_VNOM_RST 16'h1000
`define DLD_INOM_RST 16'h1000

`endif

// ---- include/dld_pkg.sv ----
// Types shared by the dead line detector files
`default_nettype none

package dld_pkg;

  // Fundamental magnitudes of the three phases, index 0 is phase 1
  typedef struct packed {
    logic [2:0][15:0] volt;
    logic [2:0][15:0] curr;
  } dld_meas_type;

  // Registered decision flags
  typedef struct packed {
    logic [2:0] volt_above;
    logic [2:0] curr_above;
    logic dead;
    logic live;
  } dld_flags_type;

endpackage

`default_nettype wire

// ---- hdl/dld_cmp.sv ----
// One magnitude against a percentage of its nominal value
`default_nettype none
`include "dld_map.svh"

module dld_cmp (
  input wire logic [`DLD_MAG_W-1:0] mag,
  input wire logic [`DLD_PCT_W-1:0] pct,
  input wire logic [`DLD_MAG_W-1:0] nom,
  output logic above
);

  // =====================================================================
  // Scaled compare
  // Both sides are multiplied out so no divider is needed; 23 bits hold
  // the largest product of a 16-bit value and a 7-bit percentage.
  logic [`DLD_MAG_W+`DLD_PCT_W-1:0] lhs;
  logic [`DLD_MAG_W+`DLD_PCT_W-1:0] rhs;

  assign lhs = {7'h00, mag} * {16'h0000, `DLD_PCT_SCALE};
  assign rhs = {16'h0000, pct} * {7'h00, nom};
  // Strictly above; equality counts as not above
  assign above = lhs > rhs;

endmodule

`default_nettype wire

// ---- tb/dld_four_model.sv ----
// Behavioural model of the stage that supplies fundamental magnitudes
`default_nettype none

module dld_four_model (
  input wire logic clk,
  input wire logic nrst,
  input wire dld_pkg::dld_meas_type set_meas,
  output var dld_pkg::dld_meas_type fund
);
  timeunit 1ns;
  timeprecision 1ps;

  // =====================================================================
  // Magnitude output stage
  // One register stage mimics the output latch of the real calculation;
  // a real stage never offers its next result in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fund <= '0;
    end else begin
      fund <= set_meas;
    end
  end
endmodule

`default_nettype wire

// ---- tb/tb_dead_line_detector.sv ----
// Self-checking bench for the dead line detector
`default_nettype none
`include "dld_map.svh"

module tb_dead_line_detector;
  timeunit 1ns;
  timeprecision 1ps;

  // =====================================================================
  // Signals
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`DLD_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic blk_in = 1'b0;
  dld_pkg::dld_meas_type set_meas = '0;
  dld_pkg::dld_meas_type fund;
  logic [7:0] outs;
  logic [31:0] rd;
  logic rerr;
  logic op_s;
  logic [6:0] vt_s;
  logic [6:0] it_s;
  logic [15:0] vn_s;
  logic [15:0] in_s;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;

  // Cases in struct order: phase 3..1 voltage, then phase 3..1 current
  localparam logic [95:0] CASES [6] = '{
    {16'h0259, 16'h0259, 16'h0259, 16'h0000, 16'h0000, 16'h0000},
    {16'h0259, 16'h0258, 16'h0259, 16'h0000, 16'h0000, 16'h0000},
    {16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0064, 16'h0064},
    {16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0065, 16'h0064},
    {16'h0258, 16'h0258, 16'h0258, 16'h0000, 16'h0000, 16'h0000},
    {16'h0259, 16'h0259, 16'h0259, 16'h0065, 16'h0065, 16'h0065}};
  localparam logic [7:0] OFFS [6] = '{`DLD_OFF_CTRL, `DLD_OFF_VTHR,
    `DLD_OFF_ITHR, `DLD_OFF_VNOM, `DLD_OFF_INOM, `DLD_OFF_STATUS};
  localparam logic [31:0] RSTV [6] = '{32'h0, 32'h3C, 32'h0A, 32'h1000,
    32'h1000, 32'h0};
  // Threshold writes beyond the range land on the nearest limit
  localparam logic [7:0] SAT_A [6] = '{`DLD_OFF_VTHR, `DLD_OFF_VTHR,
    `DLD_OFF_VTHR, `DLD_OFF_ITHR, `DLD_OFF_ITHR, `DLD_OFF_ITHR};
  localparam logic [31:0] SAT_W [6] = '{32'h05, 32'hC8, 32'h0A, 32'h01,
    32'h65, 32'h02};
  localparam logic [31:0] SAT_E [6] = '{32'h0A, 32'h64, 32'h0A, 32'h02,
    32'h64, 32'h02};

  // Design outputs, declared before the bundle that reads them
  logic PHASE1_VOLTAGE_ABOVE, PHASE2_VOLTAGE_ABOVE, PHASE3_VOLTAGE_ABOVE;
  logic PHASE1_CURRENT_ABOVE, PHASE2_CURRENT_ABOVE, PHASE3_CURRENT_ABOVE;
  logic DEAD_LINE_OUT, LIVE_LINE_OUT;

  assign outs = {PHASE3_VOLTAGE_ABOVE, PHASE2_VOLTAGE_ABOVE,
    PHASE1_VOLTAGE_ABOVE, PHASE3_CURRENT_ABOVE, PHASE2_CURRENT_ABOVE,
    PHASE1_CURRENT_ABOVE, DEAD_LINE_OUT, LIVE_LINE_OUT};

  // =====================================================================
  // Design, partner, clock and watchdog

  dld_top u_dut (.SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PHASE1_VOLTAGE_FUNDAMENTAL(fund.volt[0]),
    .PHASE2_VOLTAGE_FUNDAMENTAL(fund.volt[1]),
    .PHASE3_VOLTAGE_FUNDAMENTAL(fund.volt[2]),
    .PHASE1_CURRENT_FUNDAMENTAL(fund.curr[0]),
    .PHASE2_CURRENT_FUNDAMENTAL(fund.curr[1]),
    .PHASE3_CURRENT_FUNDAMENTAL(fund.curr[2]),
    .FUNCTION_BLOCK_IN(blk_in),
    .PHASE1_VOLTAGE_ABOVE(PHASE1_VOLTAGE_ABOVE),
    .PHASE2_VOLTAGE_ABOVE(PHASE2_VOLTAGE_ABOVE),
    .PHASE3_VOLTAGE_ABOVE(PHASE3_VOLTAGE_ABOVE),
    .PHASE1_CURRENT_ABOVE(PHASE1_CURRENT_ABOVE),
    .PHASE2_CURRENT_ABOVE(PHASE2_CURRENT_ABOVE),
    .PHASE3_CURRENT_ABOVE(PHASE3_CURRENT_ABOVE),
    .DEAD_LINE_OUT(DEAD_LINE_OUT), .LIVE_LINE_OUT(LIVE_LINE_OUT));

  dld_four_model u_four (.clk(sys_clk), .nrst(nrst),
    .set_meas(set_meas), .fund(fund));

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // Whole run needs about 290 cycles; the ceiling leaves wide margin
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      tally_and_finish();
    end
  end

  // =====================================================================
  // Tasks
  task automatic tally_and_finish();
    if (err_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the answer is awaited, never assumed
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    rerr = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input logic op, input logic [6:0] vt, it,
                     input logic [15:0] vn, inn);
    op_s = op;
    vt_s = vt;
    it_s = it;
    vn_s = vn;
    in_s = inn;
    apb(1'b1, `DLD_OFF_CTRL, {31'h0, op});
    apb(1'b1, `DLD_OFF_VTHR, {25'h0, vt});
    apb(1'b1, `DLD_OFF_ITHR, {25'h0, it});
    apb(1'b1, `DLD_OFF_VNOM, {16'h0, vn});
    apb(1'b1, `DLD_OFF_INOM, {16'h0, inn});
  endtask

  function automatic logic gt(input logic [15:0] m, input logic [6:0] p,
                              input logic [15:0] nom);
    return ({16'h0, m} * 32'h64) > ({25'h0, p} * {16'h0, nom});
  endfunction

  // Apply magnitudes, then compare pins and status word with the rules
  task automatic run_case(input logic [95:0] m);
    logic [2:0] va;
    logic [2:0] ia;
    logic on;
    logic dead;
    logic live;
    @(posedge sys_clk);
    set_meas <= m;
    repeat (4) @(posedge sys_clk);
    on = op_s && !blk_in;
    for (int k = 0; k < 3; k++) begin
      va[k] = on && gt(m[48+16*k +: 16], vt_s, vn_s);
      ia[k] = on && gt(m[16*k +: 16], it_s, in_s);
    end
    dead = on && va == 3'h0 && ia == 3'h0;
    live = on && va == 3'h7;
    chk("outputs", {24'h0, va, ia, dead, live}, {24'h0, outs});
    apb(1'b0, `DLD_OFF_STATUS, 32'h0);
    chk("status", {24'h0, ia, va, live, dead}, rd);
    chk("status error", 32'h0, {31'h0, rerr});
  endtask

  // =====================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, OFFS[k], 32'h0);
      chk("reset value", RSTV[k], rd);
    end
    chk("outputs off", 32'h0, {24'h0, outs});
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    apb(1'b1, `DLD_OFF_STATUS, 32'hFF);
    apb(1'b0, `DLD_OFF_STATUS, 32'h0);
    chk("status read only", 32'h0, rd);
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, SAT_A[k], SAT_W[k]);
      apb(1'b0, SAT_A[k], 32'h0);
      chk("threshold limit", SAT_E[k], rd);
    end
    // Nominal 1000: voltage limit 600, current limit 100, ties not above
    cfg(1'b1, 7'h3C, 7'h0A, 16'h03E8, 16'h03E8);
    for (int k = 0; k < 6; k++) begin
      run_case(CASES[k]);
    end
    // Block input, then operation Off, must silence every flag
    blk_in <= 1'b1;
    run_case(CASES[2]);
    run_case(CASES[5]);
    blk_in <= 1'b0;
    cfg(1'b0, 7'h3C, 7'h0A, 16'h03E8, 16'h03E8);
    run_case(CASES[2]);
    run_case(CASES[5]);
    // Doubled nominals move the limits; extreme thresholds too
    cfg(1'b1, 7'h3C, 7'h0A, 16'h07D0, 16'h07D0);
    run_case(CASES[5]);
    cfg(1'b1, 7'h64, 7'h02, 16'h03E8, 16'h03E8);
    run_case(CASES[0]);
    run_case(CASES[3]);
    tally_and_finish();
  end
endmodule

`default_nettype wire
